/* File: logic/two_wire_control_port.v */
// Purpose: Control register and master sequencer of a two-wire serial port, APB slave.
// Assumes: Open-drain pins: an enable high pulls the line low; the output value is always 0.
// Notes:   Slave address matching lives elsewhere and reports through the slave_* inputs.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.vh"
module two_wire_control_port #(
   parameter ADDR_W = 12,
   parameter DIV_W  = 16
)(
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   input  wire              serial_clock_line_in,
   output reg               serial_clock_line_out,
   output reg               serial_clock_line_oe,
   input  wire              serial_data_line_in,
   output reg               serial_data_line_out,
   output reg               serial_data_line_oe,
   input  wire              slave_active,
   input  wire              slave_tx_begin,
   input  wire              slave_rx_end,
   output reg               bus_master
);
   localparam [5:0] S_IDLE   = 6'h01;
   localparam [5:0] S_START  = 6'h02;
   localparam [5:0] S_RSTART = 6'h04;
   localparam [5:0] S_STOP   = 6'h08;
   localparam [5:0] S_RECV   = 6'h10;
   localparam [5:0] S_ACK    = 6'h20;

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave. One wait state so that prdata and pready come from flip-flops.

   wire        access   = psel & penable & pready;
   wire        hit_con  = (paddr == `TW_ADDR_CONTROL);
   wire        hit_rxd  = (paddr == `TW_ADDR_RX_DATA);
   wire        hit_div  = (paddr == `TW_ADDR_DIVIDER);
   wire        hit_any  = hit_con | hit_rxd | hit_div;
   wire        wr_con   = access & pwrite & hit_con;
   wire        wr_div   = access & pwrite & hit_div;
   wire        rd_rxd   = access & ~pwrite & hit_rxd;

   reg  [15:0]      con_r;
   reg  [DIV_W-1:0] div_r;
   reg  [7:0]       rx_byte_r;
   reg              rx_full_r;
   reg  [5:0]       state_r;
   reg  [5:0]       state_nxt;
   reg  [3:0]       phase_r;
   reg  [3:0]       phase_nxt;
   reg  [7:0]       shift_r;
   reg              rx_xfer_r;
   reg              scl_hold_nxt;
   reg              sda_hold_nxt;
   reg  [31:0]      rd_mux;
   wire [15:0]      con_view;
   wire [1:0]       pins_s;
   wire             scl_s = pins_s[1];
   wire             sda_s = pins_s[0];
   wire             tick;

   // Request bits read back as the sequencer state, so they fall the cycle it returns to idle.
   assign con_view = {con_r[15:5],
                      state_r[5],
                      state_r[4],
                      state_r[3],
                      state_r[2],
                      state_r[1]};

   always @*
   begin
      rd_mux = 32'h0000_0000;
      if (hit_con)
         rd_mux = {16'h0000, con_view};
      else if (hit_rxd)
         rd_mux = {23'h00_0000, rx_full_r, rx_byte_r};
      else if (hit_div)
         rd_mux = {{(32-DIV_W){1'b0}}, div_r};
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         if (psel & penable & ~pready)
         begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~hit_any;
         end
         else
         begin
            pslverr <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stored control bits and the slave clock release.

   wire en        = con_r[`TW_BIT_ENABLE];
   wire stretch   = con_r[`TW_BIT_STRETCH_EN];
   wire rel_set   = wr_con & pwdata[`TW_BIT_CLK_RELEASE];
   wire rel_clr_w = wr_con & ~pwdata[`TW_BIT_CLK_RELEASE] & stretch;
   wire rel_hw    = slave_tx_begin | (stretch & slave_rx_end);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         con_r <= `TW_CONTROL_RESET;
         div_r <= `TW_DIVIDER_RESET;
      end
      else
      begin
         if (wr_con)
            con_r[15:13] <= {pwdata[15], 1'b0, pwdata[13]};
         if (wr_con)
            con_r[11:5] <= pwdata[11:5];
         // Hardware clear wins over a software write: a stretch is the safe outcome.
         if (rel_hw)
            con_r[`TW_BIT_CLK_RELEASE] <= 1'b0;
         else if (rel_set)
            con_r[`TW_BIT_CLK_RELEASE] <= 1'b1;
         else if (rel_clr_w)
            con_r[`TW_BIT_CLK_RELEASE] <= 1'b0;
         con_r[4:0] <= 5'h00;
         if (wr_div)
            div_r <= pwdata[DIV_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link inputs and phase timing.

   two_flop_sync #(
      .WIDTH (2),
      .INIT  (2'b11)
   ) u_pin_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in ({serial_clock_line_in, serial_data_line_in}),
      .sync_out (pins_s)
   );

   phase_tick #(
      .WIDTH (DIV_W)
   ) u_phase_tick (
      .clk     (pclk),
      .rst_n   (presetn),
      .run     (~state_r[0]),
      .divisor (div_r),
      .tick    (tick)
   );

   // A released clock line may be held low by another device; wait for it to read high.
   wire advance = tick & (serial_clock_line_oe ? 1'b1 : scl_s);

   ////////////////////////////////////////////////////////////////////////////////
   // Request acceptance. A request that is not legal now is dropped and reads back 0.

   wire go_start  = wr_con & pwdata[`TW_BIT_START_GO] & ~bus_master;
   wire go_rstart = wr_con & pwdata[`TW_BIT_RSTART_GO] & bus_master;
   wire go_stop   = wr_con & pwdata[`TW_BIT_STOP_GO] & bus_master;
   wire go_recv   = wr_con & pwdata[`TW_BIT_RECV_GO] & bus_master;
   wire go_ack    = wr_con & pwdata[`TW_BIT_ACK_GO] & bus_master & rx_xfer_r;
   wire last      = advance & (state_nxt == S_IDLE);

   ////////////////////////////////////////////////////////////////////////////////
   // Master sequencer. Line levels are decided here and registered onto the pins.

   always @*
   begin
      state_nxt    = state_r;
      phase_nxt    = phase_r;
      scl_hold_nxt = serial_clock_line_oe;
      sda_hold_nxt = serial_data_line_oe;
      case (state_r)
         S_IDLE:
         begin
            phase_nxt    = 4'h0;
            sda_hold_nxt = 1'b0;
            scl_hold_nxt = bus_master | (slave_active & ~con_r[`TW_BIT_CLK_RELEASE]);
            if (en & go_start)
               state_nxt = S_START;
            else if (en & go_rstart)
               state_nxt = S_RSTART;
            else if (en & go_stop)
               state_nxt = S_STOP;
            else if (en & go_recv)
               state_nxt = S_RECV;
            else if (en & go_ack)
               state_nxt = S_ACK;
         end
         S_START:
         begin
            // Both lines released, then data falls, then clock falls.
            scl_hold_nxt = (phase_r == 4'h2);
            sda_hold_nxt = (phase_r != 4'h0);
            if (advance)
               phase_nxt = phase_r + 4'h1;
            if (advance & (phase_r == 4'h2))
               state_nxt = S_IDLE;
         end
         S_RSTART:
         begin
            // Data released, clock released, data falls, clock falls.
            scl_hold_nxt = (phase_r == 4'h0) | (phase_r == 4'h3);
            sda_hold_nxt = (phase_r >= 4'h2);
            if (advance)
               phase_nxt = phase_r + 4'h1;
            if (advance & (phase_r == 4'h3))
               state_nxt = S_IDLE;
         end
         S_STOP:
         begin
            // Data low under a low clock, clock released, data released.
            scl_hold_nxt = (phase_r == 4'h0);
            sda_hold_nxt = (phase_r != 4'h2);
            if (advance)
               phase_nxt = phase_r + 4'h1;
            if (advance & (phase_r == 4'h2))
               state_nxt = S_IDLE;
         end
         S_RECV:
         begin
            // Even phase: clock low; odd phase: clock released, data sampled at its end.
            scl_hold_nxt = ~phase_r[0];
            sda_hold_nxt = 1'b0;
            if (advance)
               phase_nxt = phase_r + 4'h1;
            if (advance & (phase_r == `TW_RECV_LAST_PHASE))
               state_nxt = S_IDLE;
         end
         S_ACK:
         begin
            // Data set to the stored value under a low clock, one clock pulse, data released.
            scl_hold_nxt = (phase_r != 4'h1);
            sda_hold_nxt = (phase_r != 4'h3) & ~con_r[`TW_BIT_ACK_VALUE];
            if (advance)
               phase_nxt = phase_r + 4'h1;
            if (advance & (phase_r == 4'h3))
               state_nxt = S_IDLE;
         end
         default:
         begin
            state_nxt    = S_IDLE;
            phase_nxt    = 4'h0;
            scl_hold_nxt = 1'b0;
            sda_hold_nxt = 1'b0;
         end
      endcase
      if (!en)
      begin
         state_nxt    = S_IDLE;
         phase_nxt    = 4'h0;
         scl_hold_nxt = 1'b0;
         sda_hold_nxt = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r               <= S_IDLE;
         phase_r               <= 4'h0;
         serial_clock_line_oe  <= 1'b0;
         serial_data_line_oe   <= 1'b0;
         serial_clock_line_out <= 1'b0;
         serial_data_line_out  <= 1'b0;
      end
      else
      begin
         state_r               <= state_nxt;
         phase_r               <= phase_nxt;
         serial_clock_line_oe  <= scl_hold_nxt;
         serial_data_line_oe   <= sda_hold_nxt;
         serial_clock_line_out <= 1'b0;
         serial_data_line_out  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mastership, receive byte and the received-byte flag.

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_master <= 1'b0;
         rx_xfer_r  <= 1'b0;
         shift_r    <= 8'h00;
         rx_byte_r  <= 8'h00;
         rx_full_r  <= 1'b0;
      end
      else
      begin
         if (!en)
            bus_master <= 1'b0;
         else if (last & state_r[1])
            bus_master <= 1'b1;
         else if (last & state_r[3])
            bus_master <= 1'b0;
         if (!en | (last & (state_r[1] | state_r[2] | state_r[3])))
            rx_xfer_r <= 1'b0;
         else if (last & state_r[4])
            rx_xfer_r <= 1'b1;
         if (state_r[4] & advance & phase_r[0])
            shift_r <= {shift_r[6:0], sda_s};
         // A byte landing in the same cycle as a read keeps the flag set.
         if (last & state_r[4])
         begin
            rx_byte_r <= {shift_r[6:0], sda_s};
            rx_full_r <= 1'b1;
         end
         else if (rd_rxd)
         begin
            rx_full_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: common/two_wire_map.vh */
// Purpose: Register offsets, field positions and reset values of the two-wire control port.
// Assumes: APB with 32-bit data; every register occupies one aligned word.
// Notes:   Definitions only; included by bare name.
//
// Contract
// - As receiving master, the acknowledge sequence drives ack_value: 1 NACK, 0 ACK.
// - ack_sequence_go and ack_value act only while the port is master in a master receive.
// - Writing 1 to ack_sequence_go generates an acknowledge sequence carrying ack_value.
// - Hardware clears ack_sequence_go when the acknowledge sequence ends; 0 means none running.
// - Setting master_receive_go makes the master clock in one data byte from the bus.
// - Hardware clears master_receive_go at the end of the eighth received bit.
// - Setting stop_condition_go while master generates a Stop condition.
// - Hardware clears stop_condition_go when the Stop sequence completes.
// - Setting restart_condition_go while master generates a Repeated Start condition.
// - Hardware clears restart_condition_go when the Repeated Start sequence completes.
// - Setting start_condition_go generates a Start condition and makes the port bus master.
// - Hardware clears start_condition_go when the Start sequence completes.
// - Stretch off: software may only set slave_clock_release; slave transmit start clears it.
// - As slave, the clock line is released while slave_clock_release is 1 and held low while it is 0.
// - Stretch on: software writes 0 or 1; slave transmit start and receive end clear it.
`ifndef TWO_WIRE_MAP_VH
`define TWO_WIRE_MAP_VH

`define TW_ADDR_CONTROL   12'h000
`define TW_ADDR_RX_DATA   12'h004
`define TW_ADDR_DIVIDER   12'h008

`define TW_BIT_ENABLE       15
`define TW_BIT_IDLE_STOP    13
`define TW_BIT_CLK_RELEASE  12
`define TW_BIT_STRETCH_EN   6
`define TW_BIT_ACK_VALUE    5
`define TW_BIT_ACK_GO       4
`define TW_BIT_RECV_GO      3
`define TW_BIT_STOP_GO      2
`define TW_BIT_RSTART_GO    1
`define TW_BIT_START_GO     0
`define TW_BIT_RX_FULL      8

`define TW_CONTROL_STORE_MASK 16'hBFE0
`define TW_CONTROL_RESET      16'h0000
`define TW_DIVIDER_RESET      16'h0031
`define TW_RECV_LAST_PHASE    4'hF

`endif

/* File: logic/two_flop_sync.v */
// Purpose: Two-flip-flop synchroniser for levels from outside the pclk domain.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module two_flop_sync #(
   parameter WIDTH = 2,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)(
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r   <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: logic/phase_tick.v */
// Purpose: Phase timer; pulses tick once every divisor+1 clocks while run is high.
// Assumes: divisor is static while run is high.
// Notes:   Reloads whenever run is low, so each sequence starts with a full phase.
`timescale 1ns/1ps
`default_nettype none
module phase_tick #(
   parameter WIDTH = 16
)(
   input  wire             clk,
   input  wire             rst_n,
   input  wire             run,
   input  wire [WIDTH-1:0] divisor,
   output reg              tick
);
   reg [WIDTH-1:0] count_r;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= {WIDTH{1'b0}};
         tick    <= 1'b0;
      end
      else if (!run)
      begin
         count_r <= divisor;
         tick    <= 1'b0;
      end
      else if (count_r == {WIDTH{1'b0}})
      begin
         count_r <= divisor;
         tick    <= 1'b1;
      end
      else
      begin
         count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
         tick    <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: verif/two_wire_port_monitor.sv */
// Purpose: Concurrent checks on the ports of the two-wire control port.
// Assumes: An open-drain enable high pulls its line low; a released line reads high.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.vh"
module two_wire_port_monitor #(
   parameter ADDR_W = 12,
   parameter DIV_W  = 16
)(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              serial_clock_line_in,
   input wire logic              serial_clock_line_out,
   input wire logic              serial_clock_line_oe,
   input wire logic              serial_data_line_in,
   input wire logic              serial_data_line_out,
   input wire logic              serial_data_line_oe,
   input wire logic              slave_active,
   input wire logic              slave_tx_begin,
   input wire logic              slave_rx_end,
   input wire logic              bus_master
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   property p_ready_after_access;
      psel && penable && !pready |=> pready;
   endproperty
   a_ready_after_access: assert property (p_ready_after_access)
      else $error("pready did not follow the first access cycle");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single)
      else $error("pready stood longer than one cycle");
   property p_err_decode;
      pready |-> pslverr == !(paddr == `TW_ADDR_CONTROL || paddr == `TW_ADDR_RX_DATA
                              || paddr == `TW_ADDR_DIVIDER);
   endproperty
   a_err_decode: assert property (p_err_decode)
      else $error("pslverr does not match the address decode");
   property p_write_reads_zero;
      pready && pwrite |-> prdata == 32'h0000_0000;
   endproperty
   a_write_reads_zero: assert property (p_write_reads_zero)
      else $error("prdata not zero on a write");
   property p_lines_free_after_reset;
      $rose(presetn) |-> !serial_clock_line_oe && !serial_data_line_oe && !bus_master;
   endproperty
   a_lines_free_after_reset: assert property (p_lines_free_after_reset)
      else $error("lines driven right after reset");
   // A falling data line under a released clock from a non-master is a Start.
   property p_start_makes_master;
      $rose(serial_data_line_oe) && !serial_clock_line_oe && !bus_master
         |-> ##[1:300] bus_master;
   endproperty
   a_start_makes_master: assert property (p_start_makes_master)
      else $error("Start condition did not make the port master");
   property p_start_ends_low;
      $rose(bus_master) |-> serial_clock_line_oe && serial_data_line_oe;
   endproperty
   a_start_ends_low: assert property (p_start_ends_low)
      else $error("Start sequence ended without both lines low");
   property p_stop_drops_master;
      $fell(serial_data_line_oe) && !serial_clock_line_oe && bus_master
         |-> ##[0:60] !bus_master;
   endproperty
   a_stop_drops_master: assert property (p_stop_drops_master)
      else $error("Stop condition left the port master");
   property p_slave_hold;
      slave_tx_begin && slave_active && !bus_master |-> ##[1:3] serial_clock_line_oe;
   endproperty
   a_slave_hold: assert property (p_slave_hold)
      else $error("clock line not held after slave transmit start");
   c_start: cover property ($rose(bus_master));
   c_stop: cover property ($fell(bus_master));
   c_error: cover property (pready && pslverr);
   c_slave_hold: cover property (slave_tx_begin && slave_active);
endmodule
`default_nettype wire

/* File: verif/two_wire_far_device.sv */
// Purpose: Behavioural far-side device that answers master receives on the serial lines.
// Assumes: Both lines have pull-ups, so a released line reads high.
// Notes:   With slow set it holds the clock low for 300 ns after each falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module two_wire_far_device (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       slow,
   input  wire logic [7:0] tx_byte,
   output var  logic       sda_oe,
   output var  logic       scl_oe,
   output var  logic       ack_seen,
   output var  int         n_start,
   output var  int         n_stop
);
   int bit_n;
   initial
   begin
      sda_oe = 1'h0;
      scl_oe = 1'h0;
      ack_seen = 1'h0;
      n_start = 0;
      n_stop = 0;
      bit_n = 10;
   end
   ////////////////////////////////////////////////////////////////
   always @(negedge sda)
      if (scl)
      begin
         n_start = n_start + 1;
         bit_n = 0;
      end
   always @(posedge sda)
      if (scl)
         n_stop = n_stop + 1;
   always @(posedge scl)
      if (bit_n == 9)
         ack_seen = sda;
   // Slots advance only while the clock is low, MSB first; the ack slot is left free.
   always @(negedge scl)
   begin
      if (bit_n < 10)
         bit_n = bit_n + 1;
      if (slow)
      begin
         scl_oe = 1'h1;
         #300;
         scl_oe = 1'h0;
      end
   end
   // The bit follows tx_byte, so a byte loaded after the Start still leads with its MSB.
   always @*
      sda_oe = (bit_n >= 1 && bit_n <= 8) ? !tx_byte[8 - bit_n] : 1'h0;
endmodule
`default_nettype wire

/* File: verif/tb_i2c_master_sequence_control.sv */
// Purpose: Self-checking bench of the two-wire control port against a far-side device.
// Assumes: Divisor 3 gives a 200 ns serial clock at a 25 ns pclk.
// Notes:   Registers are reached only through APB transfers.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.vh"
module tb_i2c_master_sequence_control;
   localparam logic [31:0] EN = 32'h0000_8000;
   logic        pclk, presetn, psel, penable, pwrite, slave_active, slave_tx_begin;
   logic        slave_rx_end, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdata;
   logic [7:0]  tx_byte;
   logic        rerr;
   wire logic [31:0] prdata;
   wire logic   pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, bus_master;
   wire logic   f_sda_oe, f_scl_oe, ack_seen;
   int          n_start, n_stop;
   wire logic   scl = !(scl_oe | f_scl_oe);
   wire logic   sda = !(sda_oe | f_sda_oe);
   int          n_fail, n_compared;
   two_wire_control_port i_two_wire_control_port (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_clock_line_in(scl),
      .serial_clock_line_out(scl_out), .serial_clock_line_oe(scl_oe),
      .serial_data_line_in(sda), .serial_data_line_out(sda_out),
      .serial_data_line_oe(sda_oe), .slave_active, .slave_tx_begin, .slave_rx_end,
      .bus_master);
   two_wire_far_device i_two_wire_far_device (.scl, .sda, .slow, .tx_byte,
      .sda_oe(f_sda_oe), .scl_oe(f_scl_oe), .ack_seen, .n_start, .n_stop);
   ////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'h1)
         n_fail++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      acc(1'h0, a, 32'h0000_0000);
      chk(rdata, exp);
   endtask
   // Polls the control word until the request bits in m drop, bounded.
   task automatic done(input logic [31:0] m);
      int n;
      n = 0;
      acc(1'h0, `TW_ADDR_CONTROL, 32'h0000_0000);
      while ((rdata & m) != 32'h0000_0000 && n < 200)
      begin
         acc(1'h0, `TW_ADDR_CONTROL, 32'h0000_0000);
         n++;
      end
      chk(rdata & m, 32'h0000_0000);
   endtask
   task automatic pulse(input logic tx);
      @(posedge pclk);
      slave_tx_begin <= tx;
      slave_rx_end <= !tx;
      @(posedge pclk);
      slave_tx_begin <= 1'h0;
      slave_rx_end <= 1'h0;
      repeat (2) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdc(`TW_ADDR_CONTROL, 32'h0000_0000);
      rdc(`TW_ADDR_DIVIDER, 32'h0000_0031);
      rdc(12'h00C, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0001);
      acc(1'h1, `TW_ADDR_DIVIDER, 32'h0000_0003);
      rdc(`TW_ADDR_DIVIDER, 32'h0000_0003);
      acc(1'h1, `TW_ADDR_CONTROL, EN);
      rdc(`TW_ADDR_CONTROL, EN);
      $display("test regs done");
   endtask
   task automatic t_cond(input logic [31:0] go, input int starts, input int stops);
      int s0, p0;
      s0 = n_start;
      p0 = n_stop;
      acc(1'h1, `TW_ADDR_CONTROL, EN | go);
      done(go);
      chk(32'(n_start - s0), 32'(starts));
      chk(32'(n_stop - p0), 32'(stops));
      chk({31'h0, bus_master}, {31'h0, stops == 0});
      $display("test condition %h done", go);
   endtask
   task automatic t_receive(input logic [7:0] b, input logic s);
      slow <= s;
      tx_byte <= b;
      acc(1'h1, `TW_ADDR_CONTROL, EN | 32'h0000_0008);
      done(32'h0000_0008);
      slow <= 1'h0;
      rdc(`TW_ADDR_RX_DATA, {23'h0, 1'h1, b});
      $display("test receive %h done", b);
   endtask
   task automatic t_ack(input logic v);
      acc(1'h1, `TW_ADDR_CONTROL, EN | {26'h0, v, 5'h10});
      done(32'h0000_0010);
      chk({31'h0, ack_seen}, {31'h0, v});
      chk({30'h0, scl_out, sda_out}, 32'h0000_0000);
      $display("test ack %h done", v);
   endtask
   task automatic t_ack_refused;
      acc(1'h1, `TW_ADDR_CONTROL, EN | 32'h0000_0010);
      acc(1'h0, `TW_ADDR_CONTROL, 32'h0000_0000);
      chk(rdata & 32'h0000_0010, 32'h0000_0000);
      $display("test ack refused done");
   endtask
   task automatic t_slave;
      slave_active <= 1'h1;
      acc(1'h1, `TW_ADDR_CONTROL, EN | 32'h0000_1000);
      repeat (2) @(posedge pclk);
      chk({31'h0, scl_oe}, 32'h0000_0000);
      pulse(1'h1);
      rdc(`TW_ADDR_CONTROL, EN);
      chk({31'h0, scl_oe}, 32'h0000_0001);
      acc(1'h1, `TW_ADDR_CONTROL, EN | 32'h0000_1000);
      acc(1'h1, `TW_ADDR_CONTROL, EN);
      rdc(`TW_ADDR_CONTROL, EN | 32'h0000_1000);
      pulse(1'h0);
      rdc(`TW_ADDR_CONTROL, EN | 32'h0000_1000);
      acc(1'h1, `TW_ADDR_CONTROL, EN | 32'h0000_1040);
      acc(1'h1, `TW_ADDR_CONTROL, EN | 32'h0000_0040);
      rdc(`TW_ADDR_CONTROL, EN | 32'h0000_0040);
      acc(1'h1, `TW_ADDR_CONTROL, EN | 32'h0000_1040);
      pulse(1'h0);
      rdc(`TW_ADDR_CONTROL, EN | 32'h0000_0040);
      chk({31'h0, scl_oe}, 32'h0000_0001);
      slave_active <= 1'h0;
      $display("test slave release done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   initial
   begin
      #2_000_000;
      n_fail++;
      $display("watchdog expired");
      stop_test;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, slave_active, slave_tx_begin, slave_rx_end} = 7'h00;
      {slow, paddr, pwdata, tx_byte} = 53'h0;
      n_fail = 0;
      n_compared = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      t_regs;
      t_cond(32'h0000_0001, 1, 0);
      t_ack_refused;
      t_receive(8'hA5, 1'h1);
      t_ack(1'h1);
      t_cond(32'h0000_0002, 1, 0);
      t_receive(8'h3C, 1'h0);
      t_ack(1'h0);
      t_cond(32'h0000_0004, 0, 1);
      t_ack_refused;
      t_slave;
      stop_test;
   end
endmodule
bind two_wire_control_port two_wire_port_monitor #(.ADDR_W(ADDR_W), .DIV_W(DIV_W))
   i_two_wire_port_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .serial_clock_line_in, .serial_clock_line_out,
   .serial_clock_line_oe, .serial_data_line_in, .serial_data_line_out,
   .serial_data_line_oe, .slave_active, .slave_tx_begin, .slave_rx_end, .bus_master);
`default_nettype wire
